/* include/lcps_pkg.sv */
// Purpose: Shared constants for the light channel pulse sequencer.
// Assumes: 25 MHz pclk, APB register access, 12-bit current codes.
// Notes:   All sequence times are held in milliseconds.
package lcps_pkg;
	// Clock and timebase.
	localparam int unsigned CLK_HZ   = 25_000_000;
	localparam int unsigned TICK_US  = 1000;
	localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;

	// Register byte offsets.
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_CURR   = 8'h04;
	localparam logic [7:0] A_SDLY   = 8'h08;
	localparam logic [7:0] A_PER    = 8'h0C;
	localparam logic [7:0] A_TON    = 8'h10;
	localparam logic [7:0] A_RISE   = 8'h14;
	localparam logic [7:0] A_PLAT   = 8'h18;
	localparam logic [7:0] A_FALL   = 8'h1C;
	localparam logic [7:0] A_PULSES = 8'h20;
	localparam logic [7:0] A_SEQS   = 8'h24;
	localparam logic [7:0] A_QDLY   = 8'h28;
	localparam logic [7:0] A_STAT   = 8'h2C;
	localparam logic [7:0] A_TOTAL  = 8'h30;
	localparam logic [7:0] A_DRIVE  = 8'h34;

	// Control register field positions.
	localparam int unsigned C_MODE  = 0;
	localparam int unsigned C_TRIG  = 4;
	localparam int unsigned C_TTLO  = 6;
	localparam int unsigned C_LOWP  = 7;
	localparam int unsigned C_OVRD  = 8;
	localparam int unsigned C_SMTH  = 9;
	localparam int unsigned C_RUN   = 10;

	// Drive modes and trigger modes.
	localparam logic [1:0] MODE_CW  = 2'h0;
	localparam logic [1:0] MODE_TTL = 2'h1;
	localparam logic [1:0] MODE_ANA = 2'h2;
	localparam logic [1:0] MODE_SQ  = 2'h3;
	localparam logic [1:0] TRIG_MAN = 2'h0;
	localparam logic [1:0] TRIG_TRG = 2'h1;
	localparam logic [1:0] TRIG_GAT = 2'h2;

	// Current codes: full scale, safe limit, one tenth of full scale.
	localparam logic [11:0] FULL_CODE = 12'hFFF;
	localparam logic [11:0] SAFE_CODE = 12'hCCC;
	localparam logic [11:0] LP_CODE   = 12'h199;

	// Values after reset.
	localparam logic [11:0] CURR_RST = 12'h000;
	localparam logic [15:0] PER_RST  = 16'h0064;
	localparam logic [15:0] TON_RST  = 16'h0032;
	localparam logic [15:0] TIME_RST = 16'h0000;
	localparam logic [15:0] CNT_RST  = 16'h0001;
endpackage : lcps_pkg

/* src/lcps_top.sv */
// Purpose: One light channel: drive-current sequencer with APB control.
// Assumes: Modulation and ADC inputs arrive asynchronous to pclk.
// Notes:   Sequence timing has a resolution of one millisecond tick.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Triggered mode starts the sequence on a rising modulation input.
// - Triggered mode ignores input pulses while a sequence runs.
// - Triggered mode restarts on the first pulse after completion.
// - Gated mode advances the sequence only while the input is high.
// - Gated mode holds position while input low, resumes when high.
// - TTL monitor option drives full high whenever commanded drive is nonzero.
// - Without TTL option the monitor follows the sensed source current.
// - Low power caps current at one tenth, same scale.
// - Overdrive lifts the safe current limit up to full scale.
// - Continuous mode drives a constant current, manual start only.
// - External TTL mode switches the source with the input level.
// - External analog mode follows the input, clipped at the setting.
// - Square mode waits the starting delay before the first pulse.
// - One pulse per period; period is the reciprocal of frequency.
// - Smoothing ramps up, holds the plateau, then ramps down.
// - Smoothing forces on-time to rise plus plateau plus fall.
// - Zero pulses per sequence repeats the pulse train forever.
// - Zero sequence count repeats forever, else runs that many times.
// - Inter-sequence delay inserted only when sequence count exceeds one.
// - Duration status reports infinite, a time, or an error.
module lcps_top #(
	parameter int unsigned TICK_CYCLES = lcps_pkg::TICK_CYC
) (
	// Clock, reset and clock enable.
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Modulation input and converter samples.
	input  wire logic        mod_ttl_in,
	input  wire logic [11:0] ana_in,
	input  wire logic [11:0] isense_in,
	// Drive and monitor outputs.
	output logic      [11:0] drive_code,
	output logic      [11:0] mon_code,
	output logic             mon_ttl,
	output logic             seq_running
);
	import lcps_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE, ST_START, ST_PULSE, ST_GAP, ST_DONE
	} lcps_state_e;

	lcps_state_e st_r;
	logic [1:0]  mode_r, trig_r, ttl_sy_r;
	logic [11:0] curr_r, ana_m_r, ana_r, isn_m_r, isn_r, lim, amp, lvl;
	logic [15:0] sdly_r, per_r, ton_r, rise_r, plat_r, fall_r;
	logic [15:0] pulses_r, seqs_r, qdly_r, ms_r, pcnt_r, scnt_r;
	logic [16:0] ton_eff, per_eff;
	logic [31:0] tick_r, total_r, rd;
	logic [63:0] total_sum;
	logic        ttlo_r, lowp_r, ovrd_r, smth_r, run_r, run_d_r;
	logic        tick, err, inf, wr_en, setup, mapped, hold, ttl_d_r;
	logic        start_ev, can_start, last_p, last_s;

	assign wr_en = psel & penable & pwrite & pready;
	assign setup = psel & ~penable;

	// Linear ramp value: amplitude scaled by x over d, never above amp.
	function automatic logic [11:0] ramp(input logic [11:0] a,
		input logic [16:0] x, input logic [16:0] d);
		logic [28:0] prod;
		logic [28:0] q;
		prod = {17'h00000, a} * {12'h000, x};
		q = (d == 17'h00000) ? {17'h00000, a} : prod / {12'h000, d};
		ramp = (q > {17'h00000, a}) ? a : q[11:0];
	endfunction : ramp

	// Millisecond timebase.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			tick_r <= 32'h0000_0000;
		end
		else if (ce)
		begin
			if (tick_r >= TICK_CYCLES - 1)
				tick_r <= 32'h0000_0000;
			else
				tick_r <= tick_r + 32'h0000_0001;
		end
	assign tick = ce & (tick_r >= TICK_CYCLES - 1);

	// Pin and converter inputs pass two flops before use.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ttl_sy_r <= 2'h0;
			ttl_d_r  <= 1'b0;
			ana_m_r  <= 12'h000;
			ana_r    <= 12'h000;
			isn_m_r  <= 12'h000;
			isn_r    <= 12'h000;
		end
		else if (ce)
		begin
			ttl_sy_r <= {ttl_sy_r[0], mod_ttl_in};
			ttl_d_r  <= ttl_sy_r[1];
			ana_m_r  <= ana_in;
			ana_r    <= ana_m_r;
			isn_m_r  <= isense_in;
			isn_r    <= isn_m_r;
		end

	// Register writes.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			mode_r   <= MODE_CW;
			trig_r   <= TRIG_MAN;
			ttlo_r   <= 1'b0;
			lowp_r   <= 1'b0;
			ovrd_r   <= 1'b0;
			smth_r   <= 1'b0;
			run_r    <= 1'b0;
			curr_r   <= CURR_RST;
			sdly_r   <= TIME_RST;
			per_r    <= PER_RST;
			ton_r    <= TON_RST;
			rise_r   <= TIME_RST;
			plat_r   <= TIME_RST;
			fall_r   <= TIME_RST;
			pulses_r <= CNT_RST;
			seqs_r   <= CNT_RST;
			qdly_r   <= TIME_RST;
		end
		else if (ce && wr_en)
		begin
			case (paddr)
				A_CTRL:
				begin
					mode_r <= pwdata[C_MODE +: 2];
					trig_r <= pwdata[C_TRIG +: 2];
					ttlo_r <= pwdata[C_TTLO];
					lowp_r <= pwdata[C_LOWP];
					ovrd_r <= pwdata[C_OVRD];
					smth_r <= pwdata[C_SMTH];
					run_r  <= pwdata[C_RUN];
				end
				A_CURR:   curr_r   <= pwdata[11:0];
				A_SDLY:   sdly_r   <= pwdata[15:0];
				A_PER:    per_r    <= pwdata[15:0];
				A_TON:    ton_r    <= pwdata[15:0];
				A_RISE:   rise_r   <= pwdata[15:0];
				A_PLAT:   plat_r   <= pwdata[15:0];
				A_FALL:   fall_r   <= pwdata[15:0];
				A_PULSES: pulses_r <= pwdata[15:0];
				A_SEQS:   seqs_r   <= pwdata[15:0];
				A_QDLY:   qdly_r   <= pwdata[15:0];
				default:  ;
			endcase
		end

	// Current ceiling and clipped setpoint.
	always_comb
	begin
		if (lowp_r)
			lim = LP_CODE;
		else if (ovrd_r)
			lim = FULL_CODE;
		else
			lim = SAFE_CODE;
		amp = (curr_r > lim) ? lim : curr_r;
	end

	// A zero period is treated as one millisecond so the train still steps.
	assign ton_eff = smth_r ? ({1'b0, rise_r} + {1'b0, plat_r}
		+ {1'b0, fall_r}) : {1'b0, ton_r};
	assign per_eff = (per_r == 16'h0000) ? 17'h00001 : {1'b0, per_r};
	assign err = ton_eff > per_eff;
	assign inf = (pulses_r == 16'h0000) | (seqs_r == 16'h0000);

	// Gated mode freezes the sequencer while the input sits low.
	assign hold = (trig_r == TRIG_GAT) & ~ttl_sy_r[1];
	assign can_start = (st_r == ST_IDLE) | (st_r == ST_DONE);
	always_comb
	begin
		case (trig_r)
			TRIG_TRG: start_ev = run_r & ttl_sy_r[1] & ~ttl_d_r;
			TRIG_GAT: start_ev = run_r & ttl_sy_r[1] & (st_r == ST_IDLE);
			default:  start_ev = run_r & ~run_d_r;
		endcase
	end
	assign last_p = (pulses_r != 16'h0000)
		& (pcnt_r == pulses_r - 16'h0001);
	assign last_s = (seqs_r != 16'h0000)
		& (scnt_r == seqs_r - 16'h0001);

	// Square sequence state machine.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			st_r    <= ST_IDLE;
			ms_r    <= 16'h0000;
			pcnt_r  <= 16'h0000;
			scnt_r  <= 16'h0000;
			run_d_r <= 1'b0;
		end
		else if (ce)
		begin
			run_d_r <= run_r;
			if (!run_r || mode_r != MODE_SQ)
			begin
				st_r <= ST_IDLE;
				ms_r <= 16'h0000;
			end
			else if (start_ev && can_start)
			begin
				st_r   <= (sdly_r == 16'h0000) ? ST_PULSE : ST_START;
				ms_r   <= 16'h0000;
				pcnt_r <= 16'h0000;
				scnt_r <= 16'h0000;
			end
			else if (tick && !hold)
			begin
				case (st_r)
					ST_START:
						if (ms_r == sdly_r - 16'h0001)
						begin
							st_r <= ST_PULSE;
							ms_r <= 16'h0000;
						end
						else
							ms_r <= ms_r + 16'h0001;
					ST_PULSE:
						if ({1'b0, ms_r} >= per_eff - 17'h00001)
						begin
							ms_r <= 16'h0000;
							if (last_p)
							begin
								pcnt_r <= 16'h0000;
								if (last_s)
									st_r <= ST_DONE;
								else
								begin
									scnt_r <= scnt_r + 16'h0001;
									if (seqs_r > 16'h0001
										&& qdly_r != 16'h0000)
										st_r <= ST_GAP;
								end
							end
							else if (pulses_r != 16'h0000)
								pcnt_r <= pcnt_r + 16'h0001;
							// Zero pulse count never ends the train.
						end
						else
							ms_r <= ms_r + 16'h0001;
					ST_GAP:
						if (ms_r == qdly_r - 16'h0001)
						begin
							st_r <= ST_PULSE;
							ms_r <= 16'h0000;
						end
						else
							ms_r <= ms_r + 16'h0001;
					default: ;
				endcase
			end
		end

	// Commanded drive level for each mode.
	always_comb
	begin
		lvl = 12'h000;
		case (mode_r)
			MODE_CW:
				lvl = run_r ? amp : 12'h000;
			MODE_TTL:
				lvl = (run_r & ttl_sy_r[1]) ? amp : 12'h000;
			MODE_ANA:
				lvl = !run_r ? 12'h000
					: (ana_r > amp) ? amp : ana_r;
			default:
				if (st_r == ST_PULSE)
				begin
					if (!smth_r)
						lvl = ({1'b0, ms_r} < ton_eff) ? amp : 12'h000;
					else if (ms_r < rise_r)
						lvl = ramp(amp, {1'b0, ms_r}, {1'b0, rise_r});
					else if ({1'b0, ms_r} < {1'b0, rise_r}
						+ {1'b0, plat_r})
						lvl = amp;
					else if ({1'b0, ms_r} < ton_eff)
						lvl = ramp(amp, ton_eff - {1'b0, ms_r},
							{1'b0, fall_r});
					else
						lvl = 12'h000;
				end
		endcase
	end

	// Drive, monitor and sequence-running outputs.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			drive_code  <= 12'h000;
			mon_code    <= 12'h000;
			mon_ttl     <= 1'b0;
			seq_running <= 1'b0;
		end
		else if (ce)
		begin
			drive_code  <= lvl;
			mon_ttl     <= ttlo_r & (drive_code != 12'h000);
			if (ttlo_r)
				mon_code <= (drive_code != 12'h000)
					? FULL_CODE : 12'h000;
			else
				mon_code <= isn_r;
			seq_running <= (st_r == ST_START) | (st_r == ST_PULSE)
				| (st_r == ST_GAP);
		end

	// Finite run length in milliseconds, saturating at the word width.
	assign total_sum = {48'h0, sdly_r}
		+ {48'h0, seqs_r} * {48'h0, pulses_r} * {47'h0, per_eff}
		+ ({48'h0, seqs_r} - 64'h1) * {48'h0, qdly_r};
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			total_r <= 32'h0000_0000;
		end
		else if (ce)
		begin
			total_r <= (inf | err) ? 32'h0000_0000
				: (total_sum[63:32] != 32'h0) ? 32'hFFFF_FFFF
				: total_sum[31:0];
		end

	// Read mux, captured in the setup phase so read data comes from a flop.
	always_comb
	begin
		mapped = 1'b1;
		rd = 32'h0000_0000;
		case (paddr)
			A_CTRL:
			begin
				rd[C_MODE +: 2] = mode_r;
				rd[C_TRIG +: 2] = trig_r;
				rd[C_TTLO] = ttlo_r;
				rd[C_LOWP] = lowp_r;
				rd[C_OVRD] = ovrd_r;
				rd[C_SMTH] = smth_r;
				rd[C_RUN] = run_r;
			end
			A_CURR:   rd[11:0] = curr_r;
			A_SDLY:   rd[15:0] = sdly_r;
			A_PER:    rd[15:0] = per_r;
			A_TON:    rd[15:0] = ton_r;
			A_RISE:   rd[15:0] = rise_r;
			A_PLAT:   rd[15:0] = plat_r;
			A_FALL:   rd[15:0] = fall_r;
			A_PULSES: rd[15:0] = pulses_r;
			A_SEQS:   rd[15:0] = seqs_r;
			A_QDLY:   rd[15:0] = qdly_r;
			A_STAT:   rd[3:0] = {st_r == ST_DONE, inf, err, seq_running};
			A_TOTAL:  rd = total_r;
			A_DRIVE:  rd[11:0] = drive_code;
			default:  mapped = 1'b0;
		endcase
	end

	// One access cycle per transfer, no wait states.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (ce)
		begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			if (setup && !pwrite)
				prdata <= rd;
		end
endmodule : lcps_top

`default_nettype wire

/* bench/lcps_top_properties.sv */
// Purpose: Port-level assertions for the light channel sequencer.
// Assumes: Single pclk domain, presetn active low.
// Notes:   Sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module lcps_top_properties #(
	parameter int unsigned TICK_CYCLES = 10
) (
	// Clock, reset and enable.
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	// APB.
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Modulation and samples.
	input wire logic        mod_ttl_in,
	input wire logic [11:0] ana_in,
	input wire logic [11:0] isense_in,
	// Outputs.
	input wire logic [11:0] drive_code,
	input wire logic [11:0] mon_code,
	input wire logic        mon_ttl,
	input wire logic        seq_running
);
	import lcps_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_RDY_SETUP: assert property (psel && !penable && ce |=> pready)
		else $error("pready missing after setup");
	AST_RDY_ONE: assert property (pready && ce |=> !pready)
		else $error("pready longer than one cycle");
	AST_ERR_IN_RDY: assert property (pslverr |-> pready)
		else $error("pslverr outside access");
	AST_ERR_RD_ZERO: assert property (pready && pslverr && !pwrite
		|-> prdata == 32'h0) else $error("refused read not zero");
	AST_RDATA_HOLD: assert property ($changed(prdata) |-> pready)
		else $error("prdata moved outside access");
	AST_TTL_FULL: assert property (mon_ttl |-> mon_code == FULL_CODE)
		else $error("ttl monitor not full scale");
	AST_TTL_CAUSE: assert property (mon_ttl |-> drive_code != 12'h0 ||
		$past(drive_code) != 12'h0) else $error("ttl monitor without drive");
	AST_CE_HOLD: assert property (!ce |=> $stable(drive_code) &&
		$stable(seq_running) && $stable(mon_code))
		else $error("state moved with ce low");
	COV_ERR: cover property (pready && pslverr);
	COV_TTL: cover property ($rose(mon_ttl));
	COV_RUN: cover property ($rose(seq_running));
	COV_CE: cover property (!ce ##1 ce);
endmodule : lcps_top_properties
bind lcps_top lcps_top_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.mod_ttl_in(mod_ttl_in), .ana_in(ana_in), .isense_in(isense_in),
	.drive_code(drive_code), .mon_code(mon_code), .mon_ttl(mon_ttl),
	.seq_running(seq_running));
`default_nettype wire

/* bench/lcps_src.sv */
// Purpose: External TTL and analog source with a current sense path.
// Assumes: Levels are commanded by the bench.
// Notes:   Sensed current is half the commanded code.
`timescale 1ns/1ps
`default_nettype none
module lcps_src (
	// Clock and commands.
	input wire logic         pclk,
	input wire logic         want_hi,
	input wire logic [11:0]  want_ana,
	// Channel drive.
	input wire logic [11:0]  drive_code,
	// Stimulus and sense.
	output var logic         mod_ttl_in,
	output var logic [11:0]  ana_in,
	output var logic [11:0]  isense_in
);
	initial
	begin
		mod_ttl_in = 1'h0;
		ana_in = 12'h0;
		isense_in = 12'h0;
	end
	// Halving the sense exposes a monitor that echoes the command.
	always @(posedge pclk)
	begin
		mod_ttl_in <= want_hi;
		ana_in <= want_ana;
		isense_in <= drive_code >> 1;
	end
endmodule : lcps_src
`default_nettype wire

/* bench/lcps_top_bench.sv */
// Purpose: Self-checking bench for the light channel sequencer.
// Assumes: One millisecond tick shortened to ten pclk cycles.
// Notes:   Square timing is judged in ranges since phases align to ticks.
`timescale 1ns/1ps
`default_nettype none
module lcps_top_bench;
	import lcps_pkg::*;
	logic        pclk = 1'h0, presetn = 1'h0, ce = 1'h1;
	logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, r;
	logic        want_hi = 1'h0, e, on_q = 1'h0;
	logic [11:0] want_ana = 12'h0, d;
	wire  [31:0] prdata;
	wire         pready, pslverr, mod_ttl_in, mon_ttl, seq_running;
	wire  [11:0] ana_in, isense_in, drive_code, mon_code;
	int          errors = 0, compares = 0, cyc = 0, rises, oncyc, mids;
	int          t0, t1, tg, k;
	lcps_top #(.TICK_CYCLES(10)) dut (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mod_ttl_in(mod_ttl_in), .ana_in(ana_in),
		.isense_in(isense_in), .drive_code(drive_code),
		.mon_code(mon_code), .mon_ttl(mon_ttl), .seq_running(seq_running));
	lcps_src u_src (.pclk(pclk), .want_hi(want_hi), .want_ana(want_ana),
		.drive_code(drive_code), .mod_ttl_in(mod_ttl_in), .ana_in(ana_in),
		.isense_in(isense_in));
	always #20 pclk = ~pclk;
	// The cycle count steps on the falling edge, so tasks that read it
	// right after a rising edge see one settled value.
	always @(negedge pclk) cyc++;
	// Pulse starts, lit cycles and ramp steps below the 800 amplitude.
	always @(posedge pclk)
	begin
		on_q <= drive_code != 12'h0;
		if (drive_code != 12'h0) oncyc++;
		if (drive_code != 12'h0 && drive_code != 12'h800) mids++;
		if (drive_code != 12'h0 && !on_q)
		begin
			rises++;
			t1 = t0;
			t0 = cyc;
		end
	end
	task automatic wrap_up;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	task automatic cmp(input string n, input logic [31:0] x, g);
		compares++;
		if (g !== x)
		begin
			errors++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask : cmp
	task automatic rng(input string n, input int v, lo, hi);
		compares++;
		if (v < lo || v > hi)
		begin
			errors++;
			$display("Error %s expected %0d..%0d seen %0d", n, lo, hi, v);
		end
	endtask : rng
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] v);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'h1;
		// The request stands until pready is seen high at a rising edge.
		do @(posedge pclk); while (pready !== 1'h1 && ++n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 50) errors++;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'h1, a, v);
	endtask : wr
	task automatic chk(input string n, input logic [7:0] a,
		input logic [31:0] x);
		apb(1'h0, a, 32'h0);
		cmp(n, x, r);
	endtask : chk
	task automatic dchk(input string n, input logic [11:0] x);
		repeat (8) @(posedge pclk);
		cmp(n, {20'h0, x}, {20'h0, drive_code});
	endtask : dchk
	function automatic logic [31:0] cf(input logic [1:0] m, t,
		input logic [4:0] f);
		return {21'h0, f, t, 2'h0, m};
	endfunction : cf
	task automatic sq(input logic [31:0] s, p, o, n, q, g);
		wr(A_SDLY, s);
		wr(A_PER, p);
		wr(A_TON, o);
		wr(A_PULSES, n);
		wr(A_SEQS, q);
		wr(A_QDLY, g);
	endtask : sq
	task automatic go(input logic [31:0] c);
		wr(A_CTRL, 32'h0);
		repeat (3) @(posedge pclk);
		rises = 0;
		oncyc = 0;
		mids = 0;
		wr(A_CTRL, c);
		tg = cyc;
	endtask : go
	task automatic idle;
		int n;
		n = 0;
		repeat (3) @(posedge pclk);
		while (seq_running !== 1'h0 && n < 3000)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 3000) errors++;
	endtask : idle
	task automatic pulse;
		want_hi <= 1'h1;
		repeat (4) @(posedge pclk);
		want_hi <= 1'h0;
		repeat (4) @(posedge pclk);
	endtask : pulse
	initial
	begin
		repeat (20000) @(posedge pclk);
		errors++;
		wrap_up();
	end
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		chk("ctrl", A_CTRL, 32'h0);
		chk("curr", A_CURR, 32'h0);
		chk("per", A_PER, 32'h64);
		chk("ton", A_TON, 32'h32);
		chk("pulses", A_PULSES, 32'h1);
		chk("seqs", A_SEQS, 32'h1);
		apb(1'h1, 8'h3C, 32'h5);
		cmp("wr err", 32'h1, {31'h0, e});
		chk("rd unmapped", 8'h3C, 32'h0);
		cmp("rd err", 32'h1, {31'h0, e});
		wr(A_DRIVE, 32'hFFF);
		chk("drive ro", A_DRIVE, 32'h0);
		wr(A_CURR, 32'h800);
		go(cf(MODE_CW, TRIG_MAN, 5'h10));
		dchk("cw", 12'h800);
		cmp("mon", 32'h400, {20'h0, mon_code});
		wr(A_CTRL, cf(MODE_CW, TRIG_MAN, 5'h11));
		dchk("cw ttl", 12'h800);
		cmp("mon ttl", 32'h1, {31'h0, mon_ttl});
		wr(A_CURR, 32'hFFF);
		wr(A_CTRL, cf(MODE_CW, TRIG_MAN, 5'h10));
		dchk("safe", SAFE_CODE);
		wr(A_CTRL, cf(MODE_CW, TRIG_MAN, 5'h14));
		dchk("ovrd", FULL_CODE);
		wr(A_CTRL, cf(MODE_CW, TRIG_MAN, 5'h12));
		dchk("lowp", LP_CODE);
		wr(A_CURR, 32'h800);
		wr(A_CTRL, cf(MODE_TTL, TRIG_MAN, 5'h10));
		want_hi <= 1'h1;
		dchk("ttl hi", 12'h800);
		want_hi <= 1'h0;
		dchk("ttl lo", 12'h0);
		wr(A_CTRL, cf(MODE_ANA, TRIG_MAN, 5'h10));
		want_ana <= 12'h300;
		dchk("ana", 12'h300);
		want_ana <= 12'hA00;
		dchk("ana clip", 12'h800);
		wr(A_CTRL, cf(MODE_ANA, TRIG_MAN, 5'h12));
		want_ana <= 12'h100;
		dchk("lp scale", 12'h100);
		want_ana <= 12'h300;
		dchk("lp clip", LP_CODE);
		// On-time stays under the period in every legal set below.
		sq(2, 4, 2, 2, 1, 9);
		chk("total", A_TOTAL, 32'hA);
		go(cf(MODE_SQ, TRIG_MAN, 5'h10));
		idle();
		cmp("pulses", 32'h2, rises);
		rng("delay", t1 - tg, 14, 23);
		rng("period", t0 - t1, 30, 40);
		rng("on", oncyc, 20, 42);
		sq(0, 3, 1, 1, 2, 5);
		chk("total 2", A_TOTAL, 32'hB);
		go(cf(MODE_SQ, TRIG_MAN, 5'h10));
		idle();
		cmp("seqs", 32'h2, rises);
		rng("gap", t0 - t1, 70, 90);
		sq(0, 3, 1, 1, 1, 0);
		go(cf(MODE_SQ, TRIG_TRG, 5'h10));
		repeat (20) @(posedge pclk);
		cmp("armed", 32'h0, {31'h0, seq_running});
		pulse();
		repeat (5) @(posedge pclk);
		pulse();
		idle();
		cmp("trig once", 32'h1, rises);
		pulse();
		idle();
		cmp("retrig", 32'h2, rises);
		sq(0, 2, 1, 0, 1, 0);
		chk("inf", A_STAT, 32'hC);
		cmp("inf bit", 32'h4, r & 32'h4);
		chk("tot inf", A_TOTAL, 32'h0);
		go(cf(MODE_SQ, TRIG_GAT, 5'h10));
		want_hi <= 1'h1;
		repeat (60) @(posedge pclk);
		ce <= 1'h0;
		repeat (8) @(posedge pclk);
		ce <= 1'h1;
		repeat (20) @(posedge pclk);
		rng("gate on", rises, 3, 9);
		want_hi <= 1'h0;
		repeat (10) @(posedge pclk);
		k = rises;
		d = drive_code;
		repeat (60) @(posedge pclk);
		cmp("held", k, rises);
		cmp("held lvl", {20'h0, d}, {20'h0, drive_code});
		want_hi <= 1'h1;
		repeat (60) @(posedge pclk);
		rng("resume", rises - k, 2, 4);
		wr(A_CTRL, 32'h0);
		sq(0, 2, 5, 1, 1, 0);
		chk("err", A_STAT, 32'h2);
		cmp("err bit", 32'h2, r & 32'h2);
		chk("tot err", A_TOTAL, 32'h0);
		sq(0, 6, 1, 1, 1, 0);
		// A two tick rise leaves one visible half-amplitude step.
		wr(A_RISE, 2);
		wr(A_PLAT, 1);
		wr(A_FALL, 1);
		go(cf(MODE_SQ, TRIG_MAN, 5'h18));
		idle();
		rng("smooth on", oncyc, 20, 32);
		rng("ramp", mids, 1, 30);
		wrap_up();
	end
endmodule : lcps_top_bench
`default_nettype wire
